// ===== rtl/edge_detect_pkg.sv
// package: offsets, fields, reset values and carriers of the edge detector
package edge_detect_pkg;

  // --------------------------------------------------------------
  // register indices (byte address is four times the index)
  // --------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [13:0] IDX_THRESH_REPORT = 14'h0000;
  localparam logic [13:0] IDX_SEARCH_MULT = 14'h0806;
  localparam logic [13:0] IDX_PEAK_POS = 14'h1000;
  localparam logic [13:0] IDX_PEAK_MAG = 14'h1002;
  localparam logic [13:0] IDX_RX_ANT_DELAY = 14'h1804;
  localparam logic [13:0] IDX_TUNING_WORD = 14'h1806;
  localparam logic [13:0] IDX_REPLICA_COEF = 14'h2804;

  // --------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------
  localparam int NOISE_FACTOR_LSB = 0;
  localparam int NOISE_FACTOR_W = 5;
  localparam int PEAK_FACTOR_LSB = 5;
  localparam int PEAK_FACTOR_W = 3;
  localparam int PEAK_FACTOR_FRAC = 1;
  localparam int REPLICA_FRAC = 16;
  localparam logic [7:0] SEARCH_MULT_RESET = 8'h6C;
  localparam logic [15:0] RX_ANT_DELAY_RESET = 16'h0000;
  localparam logic [15:0] TUNING_WORD_RESET = 16'h0000;
  localparam logic [15:0] REPLICA_COEF_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] noise_level;
    logic [15:0] noise_peak;
    logic [15:0] clock_offset;
    logic [15:0] peak_index;
    logic [15:0] peak_magnitude;
    logic [39:0] raw_rx_timestamp;
    logic [15:0] first_path_adjust;
  } analysis_t;

  typedef struct packed {
    logic [NOISE_FACTOR_W-1:0] noise_threshold_factor;
    logic [PEAK_FACTOR_W-1:0] peak_noise_factor;
    logic [15:0] rx_antenna_delay;
    logic [15:0] pulse_rate_tuning_word;
    logic [15:0] replica_avoid_coefficient;
  } config_t;

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] search_mult;
    logic [15:0] rx_ant_delay;
    logic [15:0] tuning_word;
    logic [15:0] replica_coef;
    logic [15:0] thresh_report;
    logic [15:0] peak_pos;
    logic [15:0] peak_mag;
    logic [39:0] adjusted_ts;
    logic done;
  } state_t;

  localparam state_t STATE_RESET = '{
    search_mult: SEARCH_MULT_RESET,
    rx_ant_delay: RX_ANT_DELAY_RESET,
    tuning_word: TUNING_WORD_RESET,
    replica_coef: REPLICA_COEF_RESET,
    default: '0
  };

endpackage

// ===== rtl/sat_scale.sv
// unsigned multiply, right shift and saturate to the output width
`timescale 1ns/10ps
module sat_scale
#(
  parameter int AW = 16,
  parameter int BW = 16,
  parameter int SHIFT = 0,
  parameter int OW = 16
)
(
  // operands
  input wire logic [AW-1:0] a,
  input wire logic [BW-1:0] b,
  // result
  output logic [OW-1:0] y
);

  logic [AW+BW-1:0] prod;
  logic [AW+BW-1:0] shifted;

  always_comb
  begin
    prod = a * b;
    shifted = prod >> SHIFT;
    if (|shifted[AW+BW-1:OW])
      y = '1;
    else
      y = shifted[OW-1:0];
  end

endmodule

// ===== rtl/edge_detect_regs.sv
// register bank and threshold/timestamp logic of the edge detector
//
// Functional notes
// - a read-only 16-bit report holds the noise-derived path threshold.
// - bits 4-0 of the multiplier byte scale the noise level; reset 12.
// - bits 7-5 scale the noise peak in halves; reset 3 (x1.5).
// - a read-only 16-bit report holds the strongest path index per pass.
// - a read-only 16-bit report holds the magnitude at that index.
// - the 16-bit antenna delay counts 15.65 ps units (499.2 MHz x 128).
// - the stamp is raw minus antenna delay plus first path adjust.
// - the threshold is raised by itself scaled by clock offset times the coefficient.
`timescale 1ns/10ps
module edge_detect_regs
  import edge_detect_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analysis results from the detection engine
  input wire analysis_t analysis,
  // configuration towards the engine
  output config_t cfg,
  // adjusted receive timestamp
  output logic [39:0] adjusted_rx_timestamp,
  output logic result_done
);

  state_t q;
  state_t d;

  logic [15:0] noise_thr;
  logic [15:0] peak_thr;
  logic [15:0] base_thr;
  logic [15:0] replica_frac;
  logic [15:0] replica_boost;
  logic [16:0] raised_sum;
  logic [15:0] final_thr;
  logic [39:0] ts_calc;
  logic [13:0] w_idx;
  logic [13:0] r_idx;
  logic w_hit;
  logic r_hit;
  logic do_write;

  // --------------------------------------------------------------
  // threshold arithmetic
  // --------------------------------------------------------------
  sat_scale
  #(
    .AW(16),
    .BW(NOISE_FACTOR_W),
    .SHIFT(0),
    .OW(16)
  )
  u_noise_scale
  (
    .a(analysis.noise_level),
    .b(cfg.noise_threshold_factor),
    .y(noise_thr)
  );

  sat_scale
  #(
    .AW(16),
    .BW(PEAK_FACTOR_W),
    .SHIFT(PEAK_FACTOR_FRAC),
    .OW(16)
  )
  u_peak_scale
  (
    .a(analysis.noise_peak),
    .b(cfg.peak_noise_factor),
    .y(peak_thr)
  );

  sat_scale
  #(
    .AW(16),
    .BW(16),
    .SHIFT(REPLICA_FRAC),
    .OW(16)
  )
  u_replica_frac
  (
    .a(analysis.clock_offset),
    .b(cfg.replica_avoid_coefficient),
    .y(replica_frac)
  );

  sat_scale
  #(
    .AW(16),
    .BW(16),
    .SHIFT(REPLICA_FRAC),
    .OW(16)
  )
  u_replica_boost
  (
    .a(base_thr),
    .b(replica_frac),
    .y(replica_boost)
  );

  always_comb
  begin
    // larger of the noise-level and noise-peak thresholds
    if (noise_thr > peak_thr)
      base_thr = noise_thr;
    else
      base_thr = peak_thr;
    raised_sum = {1'b0, base_thr} + {1'b0, replica_boost};
    if (raised_sum[16])
      final_thr = 16'hFFFF;
    else
      final_thr = raised_sum[15:0];
    ts_calc = analysis.raw_rx_timestamp
      - {24'h000000, q.rx_ant_delay}
      + {{24{analysis.first_path_adjust[15]}},
         analysis.first_path_adjust};
  end

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  assign w_idx = q.aw_addr[15:2];
  assign r_idx = araddr[15:2];

  always_comb
  begin
    case (w_idx)
      IDX_THRESH_REPORT,
      IDX_SEARCH_MULT,
      IDX_PEAK_POS,
      IDX_PEAK_MAG,
      IDX_RX_ANT_DELAY,
      IDX_TUNING_WORD,
      IDX_REPLICA_COEF: w_hit = 1'b1;
      default: w_hit = 1'b0;
    endcase
    case (r_idx)
      IDX_THRESH_REPORT,
      IDX_SEARCH_MULT,
      IDX_PEAK_POS,
      IDX_PEAK_MAG,
      IDX_RX_ANT_DELAY,
      IDX_TUNING_WORD,
      IDX_REPLICA_COEF: r_hit = 1'b1;
      default: r_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  assign do_write = q.aw_full && q.w_full && !q.bvalid;

  always_comb
  begin
    d = q;
    d.done = 1'b0;

    // write channels captured in either order
    if (awvalid && !q.aw_full)
    begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && !q.w_full)
    begin
      d.w_full = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;

    if (do_write)
    begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = w_hit ? RESP_OKAY : RESP_SLVERR;
      case (w_idx)
        IDX_SEARCH_MULT:
        begin
          if (q.w_strb[0])
            d.search_mult = q.w_data[7:0];
        end
        IDX_RX_ANT_DELAY:
        begin
          if (q.w_strb[0])
            d.rx_ant_delay[7:0] = q.w_data[7:0];
          if (q.w_strb[1])
            d.rx_ant_delay[15:8] = q.w_data[15:8];
        end
        IDX_TUNING_WORD:
        begin
          if (q.w_strb[0])
            d.tuning_word[7:0] = q.w_data[7:0];
          if (q.w_strb[1])
            d.tuning_word[15:8] = q.w_data[15:8];
        end
        IDX_REPLICA_COEF:
        begin
          if (q.w_strb[0])
            d.replica_coef[7:0] = q.w_data[7:0];
          if (q.w_strb[1])
            d.replica_coef[15:8] = q.w_data[15:8];
        end
        // read-only reports ignore writes
        default: d.bresp = d.bresp;
      endcase
    end

    // read: one cycle from address to data
    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    if (arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rresp = r_hit ? RESP_OKAY : RESP_SLVERR;
      case (r_idx)
        IDX_THRESH_REPORT: d.rdata = {16'h0000, q.thresh_report};
        IDX_SEARCH_MULT: d.rdata = {24'h000000, q.search_mult};
        IDX_PEAK_POS: d.rdata = {16'h0000, q.peak_pos};
        IDX_PEAK_MAG: d.rdata = {16'h0000, q.peak_mag};
        IDX_RX_ANT_DELAY: d.rdata = {16'h0000, q.rx_ant_delay};
        IDX_TUNING_WORD: d.rdata = {16'h0000, q.tuning_word};
        IDX_REPLICA_COEF: d.rdata = {16'h0000, q.replica_coef};
        default: d.rdata = 32'h00000000;
      endcase
    end

    // capture of one analysis pass
    if (analysis.valid)
    begin
      d.thresh_report = final_thr;
      d.peak_pos = analysis.peak_index;
      d.peak_mag = analysis.peak_magnitude;
      d.adjusted_ts = ts_calc;
      d.done = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= STATE_RESET;
    else if (ce)
      q <= d;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // no address or write-data handshake while frozen, or the item would be lost
  assign awready = ce && !q.aw_full;
  assign wready = ce && !q.w_full;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = ce && !q.rvalid;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;

  assign cfg.noise_threshold_factor =
    q.search_mult[NOISE_FACTOR_LSB +: NOISE_FACTOR_W];
  assign cfg.peak_noise_factor =
    q.search_mult[PEAK_FACTOR_LSB +: PEAK_FACTOR_W];
  assign cfg.rx_antenna_delay = q.rx_ant_delay;
  assign cfg.pulse_rate_tuning_word = q.tuning_word;
  assign cfg.replica_avoid_coefficient = q.replica_coef;
  assign adjusted_rx_timestamp = q.adjusted_ts;
  assign result_done = q.done;

endmodule

// ===== testbench/edge_detect_regs_props.sv
// checker: handshake, result and reset properties of the edge detector
`timescale 1ns/10ps
module edge_detect_regs_props
  import edge_detect_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // engine side
  input wire analysis_t analysis,
  input wire config_t cfg,
  input wire logic [39:0] adjusted_rx_timestamp,
  input wire logic result_done
);
  logic [39:0] ts_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------
  // stamp expected from the sampled inputs
  // ------------------------------------------
  always_ff @(posedge aclk)
  begin
    ts_q <= analysis.raw_rx_timestamp - 40'(cfg.rx_antenna_delay)
      + {{24{analysis.first_path_adjust[15]}}, analysis.first_path_adjust};
  end
  // ------------------------------------------
  // properties
  // ------------------------------------------
  sequence s_rd_take; arvalid && arready && ce; endsequence
  sequence s_take; analysis.valid && ce; endsequence
  property p_rd; s_rd_take |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read dropped");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("resp dropped");
  property p_slv; rvalid && rresp == RESP_SLVERR |-> rdata == '0; endproperty
  a_slv: assert property (p_slv) else $error("reserved data");
  property p_cfg;
    $rose(aresetn) |-> cfg.noise_threshold_factor == 5'h0C
      && cfg.peak_noise_factor == 3'h3;
  endproperty
  a_cfg: assert property (p_cfg) else $error("factor reset");
  property p_done; s_take |=> result_done; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_nodone; !analysis.valid && ce |=> !result_done; endproperty
  a_nodone: assert property (p_nodone) else $error("extra done");
  property p_ts; s_take |=> adjusted_rx_timestamp == ts_q; endproperty
  a_ts: assert property (p_ts) else $error("stamp wrong");
endmodule
bind edge_detect_regs edge_detect_regs_props i_props (.aclk(aclk),
  .aresetn(aresetn), .ce(ce), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .analysis(analysis),
  .cfg(cfg), .adjusted_rx_timestamp(adjusted_rx_timestamp),
  .result_done(result_done));

// ===== testbench/tb_edge_detect_regs.sv
// testbench: register access and result checks of the edge detector
`timescale 1ns/10ps
module tb_edge_detect_regs
  import edge_detect_pkg::*;
;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [15:0] awaddr = '0, araddr = '0, eth;
  logic [31:0] wdata = '0, r, rdata;
  logic [3:0] wstrb = '0;
  logic [2:0] prot = '0;
  logic awready, wready, bvalid, arready, rvalid, done;
  logic [1:0] bresp, rresp;
  logic [39:0] ts, ets;
  analysis_t an = '0;
  config_t cfg;
  config_t ec = '0;
  logic [31:0] seed = 32'h9068CFCF;
  int n_fail = 0, num_checks = 0;
  logic [15:0] rep [4] = '{16'h5998, 16'h51EA, 16'h8000, 16'h2E14};

  always #5 aclk = ~aclk;

  edge_detect_regs i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .analysis(an), .cfg(cfg), .adjusted_rx_timestamp(ts),
    .result_done(done)
  );
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [15:0] thr(analysis_t a, config_t c);
    logic [63:0] x, y, t;
    x = a.noise_level * c.noise_threshold_factor;
    y = (a.noise_peak * c.peak_noise_factor) >> 1;
    x = (x > 64'hFFFF) ? 64'hFFFF : x;
    y = (y > 64'hFFFF) ? 64'hFFFF : y;
    t = (x > y) ? x : y;
    x = (a.clock_offset * c.replica_avoid_coefficient) >> 16;
    t = t + ((t * x) >> 16);
    return (t > 64'hFFFF) ? 16'hFFFF : t[15:0];
  endfunction

  task automatic chk(input bit c, input string m);
    num_checks++;
    if (!c)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] e);
    bit ga, gw, bv;
    logic [1:0] br;
    ga = 0;
    gw = 0;
    bv = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ga && gw))
    begin
      @(negedge aclk);
      ga |= awready;
      gw |= wready;
      @(posedge aclk);
      if (ga) awvalid <= 0;
      if (gw) wvalid <= 0;
    end
    bready <= 1;
    while (!bv)
    begin
      @(negedge aclk);
      bv = bvalid;
      br = bresp;
      @(posedge aclk);
    end
    bready <= 0;
    chk(br === e, "bresp");
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
    input logic [1:0] e);
    bit g, rv;
    logic [31:0] d;
    logic [1:0] rs;
    g = 0;
    rv = 0;
    araddr <= a;
    arvalid <= 1;
    while (!g)
    begin
      @(negedge aclk);
      g = arready;
      @(posedge aclk);
    end
    arvalid <= 0;
    rready <= 1;
    while (!rv)
    begin
      @(negedge aclk);
      rv = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
    end
    rready <= 0;
    chk(d === ed && rs === e, "read");
  endtask

  task automatic ana();
    logic [159:0] w;
    analysis_t v;
    w = {rnd(), rnd(), rnd(), rnd(), rnd()};
    v = w[136:0];
    v.valid = 1;
    an <= v;
    @(posedge aclk);
    an.valid <= 0;
    @(negedge aclk);
    eth = thr(an, ec);
    ets = an.raw_rx_timestamp - 40'(ec.rx_antenna_delay)
      + {{24{an.first_path_adjust[15]}}, an.first_path_adjust};
    chk(done === 1'b1, "done");
    chk(ts === ets, "stamp");
    @(posedge aclk);
    rd(16'h0000, {16'h0, eth}, RESP_OKAY);
    wr(16'h4000, ~r, 4'hF, RESP_OKAY);
    rd(16'h4000, {16'h0, an.peak_index}, RESP_OKAY);
    wr(16'h4008, ~r, 4'hF, RESP_OKAY);
    rd(16'h4008, {16'h0, an.peak_magnitude}, RESP_OKAY);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------
  // sequence
  // ------------------------------------------
  initial
  begin
    #100000;
    n_fail++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(16'h2018, 32'h6C, RESP_OKAY);
    chk(cfg.noise_threshold_factor === 5'h0C, "ntf");
    r = rnd();
    wr(16'h2018, ~r, 4'h1, RESP_OKAY);
    wr(16'h2018, r, 4'h1, RESP_OKAY);
    ec.noise_threshold_factor = r[4:0];
    ec.peak_noise_factor = r[7:5];
    rd(16'h2018, {24'h0, r[7:0]}, RESP_OKAY);
    chk(cfg.peak_noise_factor === r[7:5], "pnf");
    for (int i = 0; i < 2; i++)
    begin
      r = i ? 32'h0607 : 32'h1607;
      wr(16'h6018, r, 4'h3, RESP_OKAY);
      rd(16'h6018, r, RESP_OKAY);
    end
    for (int i = 0; i < 8; i++)
    begin
      r = 32'(rep[i / 2] >> (3 * (i % 2)));
      wr(16'hA010, {~r[15:0], r[15:0]}, 4'hF, RESP_OKAY);
      rd(16'hA010, r, RESP_OKAY);
    end
    wr(16'h0000, r, 4'hF, RESP_OKAY);
    rd(16'h0000, 32'h0, RESP_OKAY);
    rd(16'h0004, 32'h0, RESP_SLVERR);
    // frozen: a result pulse and a read slot must both be ignored
    ce <= 0;
    an.valid <= 1;
    @(posedge aclk);
    an.valid <= 0;
    @(negedge aclk);
    chk(done === 1'b0 && arready === 1'b0, "frozen");
    @(posedge aclk);
    ce <= 1;
    repeat (6)
    begin
      r = rnd();
      ec.rx_antenna_delay = r[15:0];
      wr(16'h6010, r, 4'h3, RESP_OKAY);
      chk(cfg.rx_antenna_delay === r[15:0], "delay");
      r = rnd();
      r = 32'(rep[r[1:0]] >> (3 * r[2]));
      ec.replica_avoid_coefficient = r[15:0];
      wr(16'hA010, r, 4'h3, RESP_OKAY);
      ana();
    end
    summarize();
  end
endmodule
